/* File: src/tas_defines.vh */
// constants for the tape address search logic
//
// How it works
// - mark holds 12-bit address in two chars
// - load point sets address to 0001
// - motion pulses advance address while moving forward
// - file mark carries current address automatically
// - search strobe trailing edge starts digit entry
// - four digits entered before search starts
// - skip enable refreshes address before calculating
// - compare present with desired, pick speed
// - fast forward counts biased distance, then skip
// - rewind unbiased, leader reached then skip
// - slightly past target gives backspace file
// - search-then-read ends with read request pulse
// - search-then-reply ends in query unless disabled
// - query digits wait for digit request
// - untouched since mark returns mark address
// - address multiplexed onto data for marks
// - two file chars reload upper 4, lower 8
// - sequence advance marks operation finished
// - digit valid strobe per digit, four total
// - query flag held until request after fourth
// - query byte: digit low 3, switches upper 5
`ifndef TAS_DEFINES_VH
`define TAS_DEFINES_VH
`define TAS_ADDR_W        12
`define TAS_LOAD_ADDR     12'h001
`define TAS_ZERO_ADDR     12'h000
`define TAS_ONE_ADDR      12'h001
`define TAS_DIG_LAST      2'h3
`define TAS_DIG_FIRST     2'h0
`define TAS_OFF_CONFIG    12'h000
`define TAS_OFF_TUNE      12'h004
`define TAS_OFF_STATUS    12'h008
`define TAS_CFG_RESET     7'h01
`define TAS_THRESH_RESET  12'h010
`define TAS_BIAS_RESET    12'h002
`define TAS_CFG_RESP      0
`define TAS_CFG_SKIP      1
`define TAS_ZERO32        32'h0000_0000
`endif

/* File: src/tas_logic.v */
// tape address tracking, file search and position query logic with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "tas_defines.vh"
module tas_logic (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        search_then_read_strobe,
  input  wire        search_then_reply_strobe,
  input  wire        position_query_strobe,
  input  wire        output_clear,
  input  wire        tape_motion_pulse,
  input  wire        file_char_strobe,
  input  wire [7:0]  file_char_data,
  input  wire        load_address_one,
  input  wire        mark_write,
  input  wire        write_data_ack,
  input  wire        sequence_advance,
  input  wire        digit_entry_strobe,
  input  wire [2:0]  digit_input_lines,
  input  wire        digit_request,
  output reg  [7:0]  address_out_lines,
  output reg         write_data_ready,
  output reg         digit_valid_strobe,
  output reg         read_file_request,
  output reg         query_mode_flag,
  output reg         skip_file_cmd,
  output reg         backspace_file_cmd,
  output reg         fast_forward_cmd,
  output reg         rewind_cmd
);

  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_DIG   = 4'h1;
  localparam [3:0] ST_CALC  = 4'h2;
  localparam [3:0] ST_OPW   = 4'h3;
  localparam [3:0] ST_FAST  = 4'h4;
  localparam [3:0] ST_REW   = 4'h5;
  localparam [3:0] ST_DONE  = 4'h6;
  localparam [3:0] ST_QREQ  = 4'h7;
  localparam [3:0] ST_QREL  = 4'h8;
  localparam [3:0] ST_QEND  = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [2:0] tas_digit;
    input [11:0] a;
    input [1:0]  idx;
    begin
      case (idx)
        2'h0:    tas_digit = a[11:9];
        2'h1:    tas_digit = a[8:6];
        2'h2:    tas_digit = a[5:3];
        default: tas_digit = a[2:0];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the partner's strobes

  reg        srd_d_r;
  reg        srp_d_r;
  reg        pq_d_r;
  reg        tmp_d_r;
  reg        fcs_d_r;
  reg        sa_d_r;
  reg        des_d_r;
  reg        wda_d_r;
  reg        mark_d_r;
  wire       srd_fall;
  wire       srp_fall;
  wire       pq_rise;
  wire       tmp_rise;
  wire       fcs_rise;
  wire       sa_rise;
  wire       des_fall;
  wire       wda_rise;

  assign srd_fall = srd_d_r & ~search_then_read_strobe;
  assign srp_fall = srp_d_r & ~search_then_reply_strobe;
  assign pq_rise  = ~pq_d_r & position_query_strobe;
  assign tmp_rise = ~tmp_d_r & tape_motion_pulse;
  assign fcs_rise = ~fcs_d_r & file_char_strobe;
  assign sa_rise  = ~sa_d_r & sequence_advance;
  assign des_fall = des_d_r & ~digit_entry_strobe;
  assign wda_rise = ~wda_d_r & write_data_ack;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      srd_d_r  <= 1'b0;
      srp_d_r  <= 1'b0;
      pq_d_r   <= 1'b0;
      tmp_d_r  <= 1'b0;
      fcs_d_r  <= 1'b0;
      sa_d_r   <= 1'b0;
      des_d_r  <= 1'b0;
      wda_d_r  <= 1'b0;
      mark_d_r <= 1'b0;
    end else begin
      srd_d_r  <= search_then_read_strobe;
      srp_d_r  <= search_then_reply_strobe;
      pq_d_r   <= position_query_strobe;
      tmp_d_r  <= tape_motion_pulse;
      fcs_d_r  <= file_char_strobe;
      sa_d_r   <= sequence_advance;
      des_d_r  <= digit_entry_strobe;
      wda_d_r  <= write_data_ack;
      mark_d_r <= mark_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb register file

  reg  [6:0]  cfg_r;
  reg  [11:0] thresh_r;
  reg  [11:0] bias_r;
  reg  [3:0]  state_r;
  reg  [11:0] addr_r;
  reg  [11:0] want_r;
  wire        apb_setup;
  wire        apb_hit;

  assign apb_setup = psel & ~penable;
  assign apb_hit   = (paddr == `TAS_OFF_CONFIG) | (paddr == `TAS_OFF_TUNE) |
                     (paddr == `TAS_OFF_STATUS);

  // zero wait: pready rises in the first access cycle and writes land there
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= `TAS_ZERO32;
      cfg_r    <= `TAS_CFG_RESET;
      thresh_r <= `TAS_THRESH_RESET;
      bias_r   <= `TAS_BIAS_RESET;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~apb_hit;
      prdata  <= `TAS_ZERO32;
      if (apb_setup & ~pwrite) begin
        case (paddr)
          `TAS_OFF_CONFIG: prdata <= {25'h000_0000, cfg_r};
          `TAS_OFF_TUNE:   prdata <= {8'h00, bias_r, thresh_r};
          `TAS_OFF_STATUS: prdata <= {4'h0, state_r, want_r, addr_r};
          default:         prdata <= `TAS_ZERO32;
        endcase
      end
      if (psel & penable & pready & pwrite) begin
        if (paddr == `TAS_OFF_CONFIG) begin
          cfg_r <= pwdata[6:0];
        end
        if (paddr == `TAS_OFF_TUNE) begin
          thresh_r <= pwdata[11:0];
          bias_r   <= pwdata[23:12];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // search and query sequencer

  reg  [11:0] fast_cnt_r;
  reg  [11:0] mark_addr_r;
  reg         fresh_r;
  reg         reply_r;
  reg  [1:0]  dig_r;
  reg  [1:0]  qdig_r;
  reg  [11:0] qaddr_r;
  reg         char_hi_r;
  reg  [3:0]  hi_nib_r;
  reg         mchar_r;
  reg         rewinding_r;
  wire        forward;
  wire        ahead;
  wire        behind;
  wire [11:0] dist_fwd;
  wire [11:0] dist_back;
  wire        fresh_set;

  // a mark written or read in the cycle of the search-start clear must win
  assign fresh_set = (mark_write & ~mark_d_r) | (fcs_rise & ~mark_write & ~char_hi_r);
  // rewinds and backspaces move the tape backward; no counting then
  assign forward   = ~rewind_cmd & ~backspace_file_cmd & ~rewinding_r;
  assign ahead     = addr_r > want_r;
  assign behind    = addr_r < want_r;
  assign dist_fwd  = want_r - addr_r;
  assign dist_back = addr_r - want_r;

  always @(posedge clk_sys) begin
    if (sys_rst | output_clear) begin
      state_r            <= ST_IDLE;
      addr_r             <= `TAS_LOAD_ADDR;
      want_r             <= `TAS_ZERO_ADDR;
      fast_cnt_r         <= `TAS_ZERO_ADDR;
      mark_addr_r        <= `TAS_LOAD_ADDR;
      fresh_r            <= 1'b0;
      reply_r            <= 1'b0;
      dig_r              <= `TAS_DIG_FIRST;
      qdig_r             <= `TAS_DIG_FIRST;
      qaddr_r            <= `TAS_ZERO_ADDR;
      char_hi_r          <= 1'b1;
      hi_nib_r           <= 4'h0;
      mchar_r            <= 1'b0;
      rewinding_r        <= 1'b0;
      address_out_lines  <= 8'h00;
      write_data_ready   <= 1'b0;
      digit_valid_strobe <= 1'b0;
      read_file_request  <= 1'b0;
      query_mode_flag    <= 1'b0;
      skip_file_cmd      <= 1'b0;
      backspace_file_cmd <= 1'b0;
      fast_forward_cmd   <= 1'b0;
      rewind_cmd         <= 1'b0;
    end else begin
      digit_valid_strobe <= 1'b0;
      read_file_request  <= 1'b0;
      skip_file_cmd      <= 1'b0;
      // tape address tracking
      if (tmp_rise & forward) begin
        addr_r <= addr_r + `TAS_ONE_ADDR;
      end
      if (load_address_one) begin
        addr_r      <= `TAS_LOAD_ADDR;
        mark_addr_r <= `TAS_LOAD_ADDR;
      end
      // file mark read back: upper nibble then low byte
      if (fcs_rise & ~mark_write) begin
        char_hi_r <= ~char_hi_r;
        if (char_hi_r) begin
          hi_nib_r <= file_char_data[3:0];
        end else begin
          addr_r      <= {hi_nib_r, file_char_data};
          mark_addr_r <= {hi_nib_r, file_char_data};
          fresh_r     <= 1'b1;
        end
      end
      if (sa_rise) begin
        char_hi_r <= 1'b1;
      end
      // mark write: two characters carrying the live address
      if (mark_write & ~mark_d_r) begin
        mchar_r           <= 1'b0;
        write_data_ready  <= 1'b1;
        address_out_lines <= {4'h0, addr_r[11:8]};
        mark_addr_r       <= addr_r;
        fresh_r           <= 1'b1;
      end else if (mark_write & write_data_ready & wda_rise) begin
        mchar_r <= 1'b1;
        if (mchar_r) begin
          write_data_ready  <= 1'b0;
          address_out_lines <= 8'h00;
        end else begin
          address_out_lines <= addr_r[7:0];
        end
      end else if (~mark_write & mark_d_r) begin
        write_data_ready  <= 1'b0;
        address_out_lines <= 8'h00;
      end
      case (state_r)
        ST_IDLE: begin
          rewinding_r <= 1'b0;
          if (srd_fall | srp_fall) begin
            reply_r <= srp_fall;
            dig_r   <= `TAS_DIG_FIRST;
            state_r <= ST_DIG;
          end else if (pq_rise) begin
            qaddr_r         <= fresh_r ? mark_addr_r : addr_r;
            qdig_r          <= `TAS_DIG_FIRST;
            query_mode_flag <= 1'b1;
            state_r         <= ST_QREQ;
          end
        end
        ST_DIG: begin
          if (des_fall) begin
            want_r <= {want_r[8:0], digit_input_lines};
            dig_r  <= dig_r + 2'h1;
            if (dig_r == `TAS_DIG_LAST) begin
              fresh_r <= fresh_set;
              if (cfg_r[`TAS_CFG_SKIP]) begin
                skip_file_cmd <= 1'b1;
                state_r       <= ST_OPW;
              end else begin
                state_r <= ST_CALC;
              end
            end
          end
        end
        ST_CALC: begin
          if (ahead) begin
            if (dist_back <= bias_r) begin
              backspace_file_cmd <= 1'b1;
              state_r            <= ST_OPW;
            end else begin
              rewind_cmd <= 1'b1;
              state_r    <= ST_REW;
            end
          end else if (behind) begin
            if (dist_fwd > thresh_r) begin
              fast_cnt_r       <= dist_fwd - bias_r;
              fast_forward_cmd <= 1'b1;
              state_r          <= ST_FAST;
            end else begin
              skip_file_cmd <= 1'b1;
              state_r       <= ST_OPW;
            end
          end else begin
            state_r <= ST_DONE;
          end
        end
        ST_FAST: begin
          if (fast_cnt_r == `TAS_ZERO_ADDR) begin
            fast_forward_cmd <= 1'b0;
            skip_file_cmd    <= 1'b1;
            state_r          <= ST_OPW;
          end else if (tmp_rise) begin
            fast_cnt_r <= fast_cnt_r - `TAS_ONE_ADDR;
          end
        end
        ST_REW: begin
          // leader reached shows up as the rewind-done half of advance
          if (sa_rise) begin
            rewind_cmd    <= 1'b0;
            rewinding_r   <= 1'b1;
            skip_file_cmd <= 1'b1;
            state_r       <= ST_OPW;
          end
        end
        ST_OPW: begin
          if (sa_rise) begin
            backspace_file_cmd <= 1'b0;
            rewinding_r        <= 1'b0;
            state_r            <= ST_CALC;
          end
        end
        ST_DONE: begin
          if (~reply_r) begin
            read_file_request <= 1'b1;
            state_r           <= ST_IDLE;
          end else if (cfg_r[`TAS_CFG_RESP]) begin
            qaddr_r         <= addr_r;
            qdig_r          <= `TAS_DIG_FIRST;
            query_mode_flag <= 1'b1;
            state_r         <= ST_QREQ;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_QREQ: begin
          if (digit_request) begin
            // upper bits are the switch constants, digit in low three
            address_out_lines  <= {cfg_r[6:2], tas_digit(qaddr_r, qdig_r)};
            digit_valid_strobe <= 1'b1;
            state_r            <= ST_QREL;
          end
        end
        ST_QREL: begin
          if (~digit_request) begin
            address_out_lines <= 8'h00;
            qdig_r            <= qdig_r + 2'h1;
            state_r           <= (qdig_r == `TAS_DIG_LAST) ? ST_QEND : ST_QREQ;
          end
        end
        ST_QEND: begin
          if (digit_request) begin
            query_mode_flag <= 1'b0;
            state_r         <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: test/tas_logic_checker.sv */
// port checks for the tape address search logic
`timescale 1ns/1ps
`default_nettype none
module tas_logic_checker (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       mark_write,
  input wire logic       sequence_advance,
  input wire logic       digit_request,
  input wire logic [7:0] address_out_lines,
  input wire logic       write_data_ready,
  input wire logic       digit_valid_strobe,
  input wire logic       read_file_request,
  input wire logic       query_mode_flag,
  input wire logic       skip_file_cmd,
  input wire logic       backspace_file_cmd,
  input wire logic       fast_forward_cmd,
  input wire logic       rewind_cmd
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////
  property p_rfr; read_file_request |=> !read_file_request; endproperty
  a_rfr: assert property (p_rfr) else $error("read pulse too wide");
  property p_dvs; digit_valid_strobe |=> !digit_valid_strobe; endproperty
  a_dvs: assert property (p_dvs) else $error("digit strobe too wide");
  property p_dreq;
    $rose(digit_valid_strobe) |-> $past(digit_request) && query_mode_flag;
  endproperty
  a_dreq: assert property (p_dreq) else $error("digit sent unasked");
  property p_qend; $fell(query_mode_flag) |-> $past(digit_request); endproperty
  a_qend: assert property (p_qend) else $error("query flag ended early");
  property p_wdr; write_data_ready |-> $past(mark_write); endproperty
  a_wdr: assert property (p_wdr) else $error("mark data without mark");
  property p_mhi; $rose(write_data_ready) |-> address_out_lines[7:4] == 4'h0; endproperty
  a_mhi: assert property (p_mhi) else $error("first mark char high bits");
  // only one motion command at a time, else the transport gets mixed orders
  property p_mot;
    !(fast_forward_cmd && rewind_cmd) && !(backspace_file_cmd && (fast_forward_cmd || rewind_cmd));
  endproperty
  a_mot: assert property (p_mot) else $error("motion commands overlap");
  property p_rend; $fell(rewind_cmd) |-> $past(sequence_advance); endproperty
  a_rend: assert property (p_rend) else $error("rewind dropped early");
  property p_rskp; $fell(rewind_cmd) |-> ##[0:3] skip_file_cmd; endproperty
  a_rskp: assert property (p_rskp) else $error("no skip after rewind");
  c_rfr: cover property (read_file_request);
  c_qry: cover property ($rose(query_mode_flag));
  c_rew: cover property ($rose(rewind_cmd));
  c_bk: cover property ($rose(backspace_file_cmd));
endmodule
bind tas_logic tas_logic_checker i_chk (
  .clk_sys            (clk_sys),
  .sys_rst            (sys_rst),
  .mark_write         (mark_write),
  .sequence_advance   (sequence_advance),
  .digit_request      (digit_request),
  .address_out_lines  (address_out_lines),
  .write_data_ready   (write_data_ready),
  .digit_valid_strobe (digit_valid_strobe),
  .read_file_request  (read_file_request),
  .query_mode_flag    (query_mode_flag),
  .skip_file_cmd      (skip_file_cmd),
  .backspace_file_cmd (backspace_file_cmd),
  .fast_forward_cmd   (fast_forward_cmd),
  .rewind_cmd         (rewind_cmd)
);
`default_nettype wire

/* File: test/tas_tape_model.sv */
// tape controller model answering motion and file commands
`timescale 1ns/1ps
`default_nettype none
module tas_tape_model (
  input  wire logic        clk_sys,
  input  wire logic        skip_file_cmd,
  input  wire logic        backspace_file_cmd,
  input  wire logic        fast_forward_cmd,
  input  wire logic        rewind_cmd,
  input  wire logic        run_motion,
  input  wire logic        read_mark,
  input  wire logic [11:0] skip_addr,
  input  wire logic [11:0] back_addr,
  output logic             tape_motion_pulse,
  output logic             file_char_strobe,
  output logic [7:0]       file_char_data,
  output logic             sequence_advance
);
  initial begin
    {tape_motion_pulse, file_char_strobe, file_char_data, sequence_advance} = '0;
  end
  // one motion pulse every second clock while tape streams forward
  always @(posedge clk_sys) begin
    tape_motion_pulse <= (fast_forward_cmd || run_motion) ? ~tape_motion_pulse : 1'b0;
  end
  task automatic send_char(input logic [7:0] c);
    file_char_data <= c;
    @(posedge clk_sys);
    file_char_strobe <= 1'b1;
    @(posedge clk_sys);
    file_char_strobe <= 1'b0;
    @(posedge clk_sys);
    file_char_data <= ~c; // released lines must not keep the char
  endtask
  task automatic op_done();
    sequence_advance <= 1'b1;
    @(posedge clk_sys);
    sequence_advance <= 1'b0;
  endtask
  always begin
    @(posedge clk_sys);
    if (skip_file_cmd || read_mark || backspace_file_cmd) begin
      repeat (4) @(posedge clk_sys);
      send_char({4'h0, backspace_file_cmd ? back_addr[11:8] : skip_addr[11:8]});
      send_char(backspace_file_cmd ? back_addr[7:0] : skip_addr[7:0]);
      op_done();
    end else if (rewind_cmd) begin
      repeat (20) @(posedge clk_sys);
      op_done();
    end
  end
endmodule
`default_nettype wire

/* File: test/test_tas_logic.sv */
// testbench for the tape address search logic
`timescale 1ns/1ps
`default_nettype none
module test_tas_logic;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, skip_addr, back_addr;
  logic [31:0] pwdata, prdata;
  logic        search_then_read_strobe, search_then_reply_strobe, position_query_strobe;
  logic        output_clear, tape_motion_pulse, file_char_strobe, load_address_one;
  logic        mark_write, write_data_ack, sequence_advance, digit_entry_strobe;
  logic        digit_request, write_data_ready, digit_valid_strobe, read_file_request;
  logic        query_mode_flag, skip_file_cmd, backspace_file_cmd, fast_forward_cmd;
  logic        rewind_cmd, run_motion, read_mark, seen_rw, seen_bk;
  logic [7:0]  file_char_data, address_out_lines;
  logic [2:0]  digit_input_lines;
  integer      n_mismatch, num_checks, n_ff, cyc;
  tas_logic i_dut (.*);
  tas_tape_model i_tape (.*);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  ////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (fast_forward_cmd && tape_motion_pulse) n_ff <= n_ff + 1;
    if (rewind_cmd) seen_rw <= 1'b1;
    if (backspace_file_cmd) seen_bk <= 1'b1;
    if (cyc == 95000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] e, input logic se);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    chk("prdata", e, prdata & m);
    chk("pslverr", {31'h0, se}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic mark(input logic [11:0] a);
    mark_write <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("mk_hi", {1'b1, 4'h0, a[11:8]}, {write_data_ready, address_out_lines});
    write_data_ack <= 1'b1;
    @(posedge clk_sys);
    write_data_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("mk_lo", a[7:0], address_out_lines);
    write_data_ack <= 1'b1;
    mark_write <= 1'b0;
    @(posedge clk_sys);
    write_data_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("mk_end", 9'h0, {write_data_ready, address_out_lines});
  endtask
  task automatic search(input logic rd, input logic [11:0] t);
    integer i;
    search_then_read_strobe <= rd;
    search_then_reply_strobe <= !rd;
    repeat (25000) @(posedge clk_sys);
    search_then_read_strobe <= 1'b0;
    search_then_reply_strobe <= 1'b0;
    for (i = 3; i >= 0; i--) begin
      @(posedge clk_sys);
      digit_input_lines <= t[3*i +: 3];
      digit_entry_strobe <= 1'b1;
      repeat (26) @(posedge clk_sys);
      digit_entry_strobe <= 1'b0;
      repeat (26) @(posedge clk_sys);
    end
  endtask
  task automatic qdig(input logic [11:0] a);
    integer i;
    for (i = 3; i >= 0; i--) begin
      digit_request <= 1'b1;
      do @(posedge clk_sys); while (digit_valid_strobe !== 1'b1);
      chk("qbyte", {5'h1F, a[3*i +: 3]}, address_out_lines);
      digit_request <= 1'b0;
      repeat (26) @(posedge clk_sys);
    end
    digit_request <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("qflag", 0, query_mode_flag);
    digit_request <= 1'b0;
  endtask
  task automatic wait_read();
    while (read_file_request !== 1'b1) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  ////////////////////////////////
  initial begin
    {n_mismatch, num_checks, n_ff, cyc} = '0;
    {psel, penable, pwrite, paddr, pwdata, search_then_read_strobe} = '0;
    {search_then_reply_strobe, position_query_strobe, output_clear, load_address_one} = '0;
    {mark_write, write_data_ack, digit_entry_strobe, digit_input_lines, digit_request} = '0;
    {run_motion, read_mark, seen_rw, seen_bk, back_addr} = '0;
    skip_addr = 12'h53c;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, 12'h000, 0, 32'hffff_ffff, 32'h0000_0001, 1'b0);
    apb(1'b0, 12'h004, 0, 32'hffff_ffff, 32'h0000_2010, 1'b0);
    apb(1'b0, 12'h00c, 0, 32'hffff_ffff, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_007d, 0, 0, 1'b0);
    apb(1'b0, 12'h000, 0, 32'hffff_ffff, 32'h0000_007d, 1'b0);
    read_mark <= 1'b1;
    @(posedge clk_sys);
    read_mark <= 1'b0;
    repeat (30) @(posedge clk_sys);
    apb(1'b0, 12'h008, 0, 32'h0000_0fff, 32'h0000_053c, 1'b0);
    run_motion <= 1'b1;
    repeat (6) @(posedge clk_sys);
    run_motion <= 1'b0;
    repeat (3) @(posedge clk_sys);
    apb(1'b0, 12'h008, 0, 32'h0000_0fff, 32'h0000_053f, 1'b0);
    position_query_strobe <= 1'b1;
    @(posedge clk_sys);
    position_query_strobe <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("qstart", 1, query_mode_flag);
    qdig(12'h53c);
    mark(12'h53f);
    skip_addr = 12'h600;
    search(1'b1, 12'h600);
    wait_read();
    chk("ff_count", 32'h0000_00bf, n_ff);
    apb(1'b0, 12'h008, 0, 32'h0000_0fff, 32'h0000_0600, 1'b0);
    skip_addr = 12'h53f;
    search(1'b0, 12'h53f);
    while (query_mode_flag !== 1'b1) @(posedge clk_sys);
    chk("rewound", 1, seen_rw);
    qdig(12'h53f);
    apb(1'b1, 12'h000, 32'h0000_007f, 0, 0, 1'b0);
    skip_addr = 12'h540;
    back_addr = 12'h53e;
    search(1'b1, 12'h53e);
    wait_read();
    chk("backspaced", 1, seen_bk);
    apb(1'b0, 12'h008, 0, 32'h0000_0fff, 32'h0000_053e, 1'b0);
    load_address_one <= 1'b1;
    @(posedge clk_sys);
    mark(12'h001);
    load_address_one <= 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
